// file: rtl/eep_defs.svh
// numeric constants shared by both ends of the two-wire eeprom link
`ifndef EEP_DEFS_SVH
`define EEP_DEFS_SVH

// device type prefix expected in the top nibble of the address byte
`define EEP_TYPE_PREFIX 4'ha
// array geometry: 128 pages of 16 bytes, 11-bit byte address
`define EEP_PAGES 128
`define EEP_PAGE_BYTES 16
`define EEP_ADDR_W 11
`define EEP_COL_W 4
`define EEP_MEM_BYTES 2048
// system clock rate in khz (10 mhz)
`define EEP_CLK_KHZ 10000
// longest self-timed programming time in microseconds
`define EEP_T_PROG_US 5000
// programming time in clock cycles, rounded down
`define EEP_PROG_CYC ((`EEP_T_PROG_US * `EEP_CLK_KHZ) / 1000)
// clock cycles per quarter of a master scl period
`define EEP_SCL_QUARTER 2'd3

`endif

// file: rtl/eep_pkg.sv
// types shared by the eeprom device end and the bus master end
package eep_pkg;

	// device protocol states, one-hot
	typedef enum logic [5:0] {
		EEP_ST_IDLE = 6'h01,
		EEP_ST_RX = 6'h02,
		EEP_ST_ACK = 6'h04,
		EEP_ST_TX = 6'h08,
		EEP_ST_TXACK = 6'h10,
		EEP_ST_PROG = 6'h20
	} eep_dev_state_t;

	// master states, one-hot
	typedef enum logic [1:0] {
		EEP_M_IDLE = 2'h1,
		EEP_M_RUN = 2'h2
	} eep_mst_state_t;

	// master command kinds
	typedef enum logic [1:0] {
		EEP_CMD_START = 2'h0,
		EEP_CMD_WRITE = 2'h1,
		EEP_CMD_READ = 2'h2,
		EEP_CMD_STOP = 2'h3
	} eep_cmd_t;

endpackage

// file: rtl/eep_link_if.sv
// two-wire link between the bus master and the eeprom device
`timescale 1ns/1ps
`default_nettype none
interface eep_link_if;
	// serial clock, driven push-pull by the master
	logic scl;
	// pull-down enables of the two ends on the shared data line
	logic sda_m_oe;
	logic sda_d_oe;
	// array protect level; the bench drives it, nothing pulls it low when left open
	logic wp;
	// resolved open-drain data line: high unless someone pulls down
	logic sda;
	assign sda = ~(sda_m_oe | sda_d_oe);

	modport dev (
		input scl,
		input sda,
		input wp,
		output sda_d_oe
	);

	modport mst (
		output scl,
		output sda_m_oe,
		input sda
	);
endinterface
`default_nettype wire

// file: rtl/eep_mst.sv
// two-wire bus master: byte-level commands in, scl and data line out
`timescale 1ns/1ps
`default_nettype none
`include "eep_defs.svh"
module eep_mst
	import eep_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	eep_link_if.mst link,
	input wire logic cmd_valid,
	input wire eep_cmd_t cmd_kind,
	input wire logic [7:0] cmd_byte,
	input wire logic cmd_ack,
	output logic cmd_ready,
	output logic done,
	output logic [7:0] rd_byte,
	output logic nack
);
	eep_mst_state_t state, next_state; // command sequencer
	eep_cmd_t kind, next_kind; // command being run
	logic [7:0] tx, next_tx; // outgoing byte, msb first
	logic ackbit, next_ackbit; // 1 = acknowledge a read byte
	logic [1:0] qc, next_qc; // cycle within a quarter
	logic [1:0] ph, next_ph; // quarter within a slot
	logic [3:0] bitn, next_bitn; // bit slot 0..8 of a byte
	logic scl, next_scl; // scl drive
	logic oe, next_oe; // data line pull-down
	logic [7:0] rx, next_rx; // incoming byte
	logic next_ready, next_done, next_nack;
	logic sda_m, sda_s; // data line synchroniser

	assign link.scl = scl;
	assign link.sda_m_oe = oe;

	// every slot: q0 scl low, q1 set data, q2 scl high, q3 sample or start/stop edge
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_tx = tx;
		next_ackbit = ackbit;
		next_qc = qc;
		next_ph = ph;
		next_bitn = bitn;
		next_scl = scl;
		next_oe = oe;
		next_rx = rx;
		next_ready = cmd_ready;
		next_done = 1'b0;
		next_nack = nack;
		case (state)
			EEP_M_IDLE: begin
				if (cmd_valid) begin
					next_kind = cmd_kind;
					next_tx = cmd_byte;
					next_ackbit = cmd_ack;
					next_qc = 2'd0;
					next_ph = 2'd0;
					next_bitn = 4'd0;
					next_ready = 1'b0;
					next_state = EEP_M_RUN;
				end
			end
			EEP_M_RUN: begin
				if (qc == 2'd0) begin
					case (ph)
						2'd0: next_scl = 1'b0;
						2'd1: begin
							// data changes only with scl low
							case (kind)
								EEP_CMD_START: next_oe = 1'b0;
								EEP_CMD_STOP: next_oe = 1'b1;
								EEP_CMD_WRITE: next_oe = (bitn < 4'd8) ? ~tx[7] : 1'b0;
								default: next_oe = (bitn < 4'd8) ? 1'b0 : ackbit;
							endcase
						end
						2'd2: next_scl = 1'b1;
						default: begin
							if (kind == EEP_CMD_START) begin
								next_oe = 1'b1;
							end else if (kind == EEP_CMD_STOP) begin
								next_oe = 1'b0;
							end
						end
					endcase
				end
				if (qc == `EEP_SCL_QUARTER - 2'd1) begin
					next_qc = 2'd0;
					next_ph = ph + 2'd1;
					if (ph == 2'd3) begin
						// slot end: sample the line, move to next bit
						if (kind == EEP_CMD_READ && bitn < 4'd8) begin
							next_rx = {rx[6:0], sda_s};
						end
						next_tx = {tx[6:0], 1'b0};
						if (kind == EEP_CMD_START || kind == EEP_CMD_STOP || bitn == 4'd8) begin
							if (kind == EEP_CMD_WRITE) begin
								next_nack = sda_s;
							end
							next_done = 1'b1;
							next_ready = 1'b1;
							next_state = EEP_M_IDLE;
						end else begin
							next_bitn = bitn + 4'd1;
						end
					end
				end else begin
					next_qc = qc + 2'd1;
				end
			end
			default: next_state = EEP_M_IDLE;
		endcase
	end

	// register stage; bus idle with scl high and data released
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= EEP_M_IDLE;
			kind <= EEP_CMD_START;
			tx <= 8'h00;
			ackbit <= 1'b0;
			qc <= 2'd0;
			ph <= 2'd0;
			bitn <= 4'd0;
			scl <= 1'b1;
			oe <= 1'b0;
			rx <= 8'h00;
			cmd_ready <= 1'b1;
			done <= 1'b0;
			nack <= 1'b0;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			state <= next_state;
			kind <= next_kind;
			tx <= next_tx;
			ackbit <= next_ackbit;
			qc <= next_qc;
			ph <= next_ph;
			bitn <= next_bitn;
			scl <= next_scl;
			oe <= next_oe;
			rx <= next_rx;
			cmd_ready <= next_ready;
			done <= next_done;
			nack <= next_nack;
			sda_m <= link.sda;
			sda_s <= sda_m;
		end
	end

	assign rd_byte = rx;
endmodule
`default_nettype wire

// file: rtl/eep_dev.sv
// two-wire eeprom device end: protocol, page buffer, self-timed programming
`timescale 1ns/1ps
`default_nettype none
`include "eep_defs.svh"
module eep_dev
	import eep_pkg::*;
#(
	parameter int PROG_CYCLES = `EEP_PROG_CYC // self-timed programming length
) (
	input wire logic clock,
	input wire logic rst,
	eep_link_if.dev link,
	output logic prog_busy,
	output logic standby
);
	// array of 2048 bytes, 11-bit address
	logic [7:0] mem [0:`EEP_MEM_BYTES-1];
	eep_dev_state_t state, next_state; // protocol state
	logic scl_m, scl_s, scl_p; // scl synchroniser and previous sample
	logic sda_m, sda_s, sda_p; // data line synchroniser and previous sample
	logic wp_m, wp_s; // protect input synchroniser
	logic [3:0] bitcnt, next_bitcnt; // bits seen in the current byte
	logic [1:0] nbyte, next_nbyte; // 0 dev addr, 1 word addr, 2 data
	logic [7:0] shift, next_shift; // receive and transmit shifter
	logic rw, next_rw; // 1 = read transfer
	logic [`EEP_ADDR_W-1:0] addr, next_addr; // byte address counter
	logic [7:0] pbuf [0:`EEP_PAGE_BYTES-1]; // page buffer
	logic [7:0] next_pbuf [0:`EEP_PAGE_BYTES-1];
	logic [`EEP_PAGE_BYTES-1:0] pvalid, next_pvalid; // loaded columns
	logic oe, next_oe; // data line pull-down
	logic mack, next_mack; // master acknowledged the last read byte
	logic [22:0] pcnt, next_pcnt; // programming cycle counter
	logic next_busy, next_standby;
	logic scl_rise, scl_fall, start_cond, stop_cond; // bus events
	logic [`EEP_COL_W-1:0] col; // page column
	logic [7:0] rd_data; // byte at the address counter

	// only a pull-down enable ever leaves this block on the link
	assign link.sda_d_oe = oe;
	assign col = addr[`EEP_COL_W-1:0];
	assign rd_data = mem[addr];

	// bus events from the synchronised, previous samples only
	always_comb begin
		scl_rise = scl_s & ~scl_p;
		scl_fall = ~scl_s & scl_p;
		// start: data falls, scl high both samples
		start_cond = scl_s & scl_p & sda_p & ~sda_s;
		// stop: data rises, scl high both samples
		stop_cond = scl_s & scl_p & ~sda_p & sda_s;
	end

	// protocol next state
	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_nbyte = nbyte;
		next_shift = shift;
		next_rw = rw;
		next_addr = addr;
		next_pbuf = pbuf;
		next_pvalid = pvalid;
		next_oe = oe;
		next_mack = mack;
		next_pcnt = pcnt;
		if (state == EEP_ST_PROG) begin
			// bus ignored until the timed cycle ends
			// so a new address byte gets no acknowledge
			next_oe = 1'b0;
			if (pcnt == 23'(PROG_CYCLES - 1)) begin
				next_state = EEP_ST_IDLE;
				next_pvalid = '0;
				next_pcnt = 23'd0;
			end else begin
				next_pcnt = pcnt + 23'd1;
			end
		end else if (start_cond) begin
			// outside programming, a start aborts whatever was going on, including a pending load
			next_state = EEP_ST_RX;
			next_bitcnt = 4'd0;
			next_nbyte = 2'd0;
			next_pvalid = '0;
			next_oe = 1'b0;
		end else if (stop_cond) begin
			next_oe = 1'b0;
			// protect high drops the load, no programming
			// the link has no pull on protect, the bench drives it low
			if (!rw && (|pvalid) && !wp_s) begin
				// stop after written data starts programming
				next_state = EEP_ST_PROG;
				next_pcnt = 23'd0;
			end else begin
				// stop after a read goes to standby
				next_state = EEP_ST_IDLE;
				next_pvalid = '0;
			end
		end else begin
			case (state)
				EEP_ST_RX: begin
					// incoming bits taken on scl rise
					if (scl_rise && bitcnt < 4'd8) begin
						next_shift = {shift[6:0], sda_s};
						next_bitcnt = bitcnt + 4'd1;
					end else if (scl_fall && bitcnt == 4'd8) begin
						next_bitcnt = 4'd0;
						// acknowledge driven through the ninth clock
						next_state = EEP_ST_ACK;
						next_oe = 1'b1;
						if (nbyte == 2'd0) begin
							// type prefix check, mismatch: silent standby
							// the three following bits are not compared
							if (shift[7:4] != `EEP_TYPE_PREFIX) begin
								next_state = EEP_ST_IDLE;
								next_oe = 1'b0;
							end
							next_rw = shift[0];
							// address byte gives upper address bits
							next_addr[`EEP_ADDR_W-1:8] = shift[3:1];
						end else if (nbyte == 2'd1) begin
							// word address acknowledged at clock 18
							next_addr[7:0] = shift;
							next_pvalid = '0;
						end else begin
							// each data byte acknowledged, any count
							next_pbuf[col] = shift;
							next_pvalid[col] = 1'b1;
							next_addr[`EEP_COL_W-1:0] = col + 4'd1;
						end
					end
				end
				EEP_ST_ACK: begin
					if (scl_fall) begin
						// release or first read bit after fall
						next_oe = 1'b0;
						next_bitcnt = 4'd0;
						if (rw) begin
							next_state = EEP_ST_TX;
							next_shift = rd_data;
							next_oe = ~rd_data[7];
							next_addr = addr + 11'd1;
						end else begin
							next_state = EEP_ST_RX;
							if (nbyte != 2'd2) begin
								next_nbyte = nbyte + 2'd1;
							end
						end
					end
				end
				EEP_ST_TX: begin
					// outgoing bits shift after each scl fall
					if (scl_fall) begin
						next_bitcnt = bitcnt + 4'd1;
						if (bitcnt == 4'd7) begin
							next_oe = 1'b0;
							next_state = EEP_ST_TXACK;
						end else begin
							next_shift = {shift[6:0], 1'b0};
							next_oe = ~shift[6];
						end
					end
				end
				EEP_ST_TXACK: begin
					// master acknowledge sampled on the ninth rise
					if (scl_rise) begin
						next_mack = ~sda_s;
					end else if (scl_fall) begin
						if (mack) begin
							next_state = EEP_ST_TX;
							next_bitcnt = 4'd0;
							next_shift = rd_data;
							next_oe = ~rd_data[7];
							next_addr = addr + 11'd1;
						end else begin
							// no acknowledge: wait for the stop in standby
							next_state = EEP_ST_IDLE;
						end
					end
				end
				default: begin
					// standby: only start and stop matter
					next_oe = 1'b0;
				end
			endcase
		end
	end

	// status outputs follow the next state so they stay registered
	always_comb begin
		next_busy = (next_state == EEP_ST_PROG);
		next_standby = (next_state == EEP_ST_IDLE);
	end

	// register stage; power-up lands in standby
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= EEP_ST_IDLE;
			bitcnt <= 4'd0;
			nbyte <= 2'd0;
			shift <= 8'h00;
			rw <= 1'b0;
			addr <= '0;
			pvalid <= '0;
			oe <= 1'b0;
			mack <= 1'b0;
			pcnt <= 23'd0;
			prog_busy <= 1'b0;
			standby <= 1'b1;
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
			wp_m <= 1'b0;
			wp_s <= 1'b0;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			nbyte <= next_nbyte;
			shift <= next_shift;
			rw <= next_rw;
			addr <= next_addr;
			pvalid <= next_pvalid;
			oe <= next_oe;
			mack <= next_mack;
			pcnt <= next_pcnt;
			prog_busy <= next_busy;
			standby <= next_standby;
			// two flops before any logic looks at the pins
			scl_m <= link.scl;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= link.sda;
			sda_s <= sda_m;
			sda_p <= sda_s;
			wp_m <= link.wp;
			wp_s <= wp_m;
		end
	end

	// page buffer holds data only; validity is tracked in pvalid
	always_ff @(posedge clock) begin
		pbuf <= next_pbuf;
	end

	// commit loaded columns in the first 16 cycles
	always_ff @(posedge clock) begin
		if (state == EEP_ST_PROG && pcnt < 23'd16 && pvalid[pcnt[3:0]]) begin
			mem[{addr[`EEP_ADDR_W-1:`EEP_COL_W], pcnt[3:0]}] <= pbuf[pcnt[3:0]];
		end
	end
endmodule
`default_nettype wire

// file: tb/eep_link_sva.sv
// link checker: timing relations on the shared wires and device status
`timescale 1ns/1ps
`default_nettype none
module eep_link_sva #(
	parameter int PROG_CYCLES = 400 // must match the device instance
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_m_oe,
	input wire logic sda_d_oe,
	input wire logic wp,
	input wire logic sda,
	input wire logic prog_busy,
	input wire logic standby
);
	// count limits, slack of two since the busy flag is registered
	localparam logic [31:0] PROG_HI = PROG_CYCLES;
	localparam logic [31:0] PROG_LO = PROG_CYCLES - 2;
	logic [31:0] busy_cnt; // cycles spent busy so far
	logic [31:0] next_busy_cnt;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// busy length counter, cleared while idle
	always_comb begin
		next_busy_cnt = prog_busy ? busy_cnt + 32'h1 : 32'h0;
	end
	always_ff @(posedge clock) begin
		busy_cnt <= rst ? 32'h0 : next_busy_cnt;
	end
	property p_shift_low;
		$changed(sda_d_oe) |-> !scl;
	endproperty
	a_shift_low: assert property (p_shift_low) else $error("device moved data while scl high");
	property p_pull_only;
		sda_d_oe |-> !sda;
	endproperty
	a_pull_only: assert property (p_pull_only) else $error("data line high while device pulls");
	property p_protect;
		$rose(prog_busy) |-> !wp;
	endproperty
	a_protect: assert property (p_protect) else $error("programming began with protect high");
	property p_ack_slot;
		$rose(sda_d_oe) |-> sda_d_oe [*8];
	endproperty
	a_ack_slot: assert property (p_ack_slot) else $error("device pull shorter than a clock slot");
	property p_prog_after_stop;
		$rose(prog_busy) |-> scl && sda && !sda_m_oe;
	endproperty
	a_prog_after_stop: assert property (p_prog_after_stop) else $error("programming without stop");
	property p_prog_len;
		$fell(prog_busy) |-> busy_cnt <= PROG_HI && busy_cnt >= PROG_LO;
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("programming time wrong");
	property p_no_ack_busy;
		prog_busy |-> !sda_d_oe;
	endproperty
	a_no_ack_busy: assert property (p_no_ack_busy) else $error("device drove line while busy");
	property p_standby_after;
		$fell(prog_busy) |-> ##[0:3] standby;
	endproperty
	a_standby_after: assert property (p_standby_after) else $error("no standby after programming");
endmodule
`default_nettype wire

// file: tb/serial_eeprom_two_wire_write_path_tb.sv
// bench: master end and device end joined, driven by byte commands
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_two_wire_write_path_tb;
	import eep_pkg::*;
	localparam int PROG = 400; // shortened so polling sees both answers
	logic clock;
	logic rst;
	logic cmd_valid;
	eep_cmd_t cmd_kind;
	logic [7:0] cmd_byte;
	logic cmd_ack;
	logic cmd_ready;
	logic done;
	logic [7:0] rd_byte;
	logic nack;
	logic prog_busy;
	logic standby;
	int fail_count;
	int check_count;
	logic [7:0] exp_pg [16]; // expected contents of the page under test
	eep_link_if link();
	eep_mst eep_mst_inst (.clock(clock), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_byte(cmd_byte), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .done(done), .rd_byte(rd_byte), .nack(nack));
	eep_dev #(.PROG_CYCLES(PROG)) eep_dev_inst (.clock(clock), .rst(rst), .link(link), .prog_busy(prog_busy),
		.standby(standby));
	eep_link_sva #(.PROG_CYCLES(PROG)) eep_link_sva_inst (.clock(clock), .rst(rst), .scl(link.scl),
		.sda_m_oe(link.sda_m_oe), .sda_d_oe(link.sda_d_oe), .wp(link.wp), .sda(link.sda),
		.prog_busy(prog_busy), .standby(standby));
	// 100 ns clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one command, held until taken, then wait for done
	task automatic cmd(input eep_cmd_t k, input logic [7:0] b, input logic a);
		int n;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_byte <= b;
		cmd_ack <= a;
		do @(posedge clock); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		for (n = 0; n < 300 && done !== 1'b1; n++) @(posedge clock);
		// a command that never ends counts as a mismatch here
		chk({6'h0, done, cmd_ready}, 8'h03);
	endtask
	// byte out, acknowledge bit compared
	task automatic wr(input logic [7:0] b, input logic en);
		cmd(EEP_CMD_WRITE, b, 1'b0);
		chk({7'h0, nack}, {7'h0, en});
	endtask
	// start, device byte, word byte
	task automatic frame(input logic [7:0] dv, input logic [7:0] wd);
		cmd(EEP_CMD_START, 8'h00, 1'b0);
		wr(dv, 1'b0);
		wr(wd, 1'b0);
	endtask
	// wait for a whole programming pass
	task automatic wait_prog();
		int n;
		for (n = 0; n < 20 && prog_busy !== 1'b1; n++) @(posedge clock);
		chk({7'h0, prog_busy}, 8'h01);
		for (n = 0; n < PROG + 20 && prog_busy !== 1'b0; n++) @(posedge clock);
		repeat (4) @(posedge clock);
		chk({6'h0, standby, prog_busy}, 8'h02);
	endtask
	// random read of page 0x32x, upper bits from the device byte
	task automatic rd_page();
		int i;
		frame(8'ha6, 8'h20);
		cmd(EEP_CMD_START, 8'h00, 1'b0);
		wr(8'ha7, 1'b0);
		for (i = 0; i < 16; i++) begin
			cmd(EEP_CMD_READ, 8'h00, i < 15);
			chk(rd_byte, exp_pg[i]);
		end
		cmd(EEP_CMD_STOP, 8'h00, 1'b0);
	endtask
	task automatic s_reset();
		chk({6'h0, standby, prog_busy}, 8'h02);
		chk({7'h0, link.sda}, 8'h01);
	endtask
	// 18 bytes from column 14: wrap overwrites columns 14 and 15
	task automatic s_page();
		int i;
		int k;
		frame(8'ha6, 8'h2e);
		for (i = 0; i < 18; i++) begin
			wr(8'h40 + 8'(i), 1'b0);
			exp_pg[(14 + i) % 16] = 8'h40 + 8'(i);
		end
		cmd(EEP_CMD_STOP, 8'h00, 1'b0);
		cmd(EEP_CMD_START, 8'h00, 1'b0);
		wr(8'ha6, 1'b1);
		cmd(EEP_CMD_STOP, 8'h00, 1'b0);
		// poll until answered, bounded
		for (k = 0; k < 10 && nack !== 1'b0; k++) begin
			cmd(EEP_CMD_START, 8'h00, 1'b0);
			cmd(EEP_CMD_WRITE, 8'ha6, 1'b0);
			cmd(EEP_CMD_STOP, 8'h00, 1'b0);
		end
		chk({7'h0, nack}, 8'h00);
		rd_page();
	endtask
	// single byte inside a full page leaves neighbours alone
	task automatic s_byte();
		frame(8'ha6, 8'h25);
		wr(8'hc3, 1'b0);
		cmd(EEP_CMD_STOP, 8'h00, 1'b0);
		exp_pg[5] = 8'hc3;
		wait_prog();
		rd_page();
	endtask
	// protect high: no programming, reads still work
	task automatic s_wp();
		link.wp <= 1'b1;
		frame(8'ha6, 8'h27);
		wr(8'h5a, 1'b0);
		cmd(EEP_CMD_STOP, 8'h00, 1'b0);
		repeat (10) @(posedge clock);
		chk({7'h0, prog_busy}, 8'h00);
		rd_page();
		link.wp <= 1'b0;
	endtask
	// wrong type prefix is not answered
	task automatic s_prefix();
		cmd(EEP_CMD_START, 8'h00, 1'b0);
		wr(8'hb6, 1'b1);
		cmd(EEP_CMD_STOP, 8'h00, 1'b0);
		chk({7'h0, standby}, 8'h01);
	endtask
	// cut transfer, then a fresh start brings the device back
	task automatic s_recover();
		cmd(EEP_CMD_START, 8'h00, 1'b0);
		cmd(EEP_CMD_READ, 8'h00, 1'b0);
		// nobody addressed, so the released line reads high
		chk(rd_byte, 8'hff);
		cmd(EEP_CMD_START, 8'h00, 1'b0);
		wr(8'ha6, 1'b0);
		cmd(EEP_CMD_STOP, 8'h00, 1'b0);
		// status is registered, let the stop settle first
		repeat (4) @(posedge clock);
		chk({6'h0, standby, prog_busy}, 8'h02);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// watchdog, about three times the expected run
	initial begin
		#3000000;
		fail_count++;
		end_of_test();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_kind = EEP_CMD_START;
		cmd_byte = 8'h00;
		cmd_ack = 1'b0;
		link.wp = 1'b0;
		fail_count = 0;
		check_count = 0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		s_reset();
		s_page();
		s_byte();
		s_wp();
		s_prefix();
		s_recover();
		end_of_test();
	end
endmodule
`default_nettype wire
